// [shared/rgb_palette_map.svh]
// Register map, reset values and field positions of the palette bank.
// Assumes inclusion from design files only; holds definitions only.
`ifndef RGB_PALETTE_MAP_SVH
`define RGB_PALETTE_MAP_SVH
`define ADDR_CONTROL 8'h02
`define ADDR_RED0 8'h03
`define ADDR_GRN0 8'h04
`define ADDR_BLU0 8'h05
`define ADDR_RED1 8'h06
`define ADDR_GRN1 8'h07
`define ADDR_BLU1 8'h08
`define ADDR_SEL12 8'h09
`define ADDR_SEL34 8'h0A
`define RST_ALT0 8'h28
`define RST_ALT1 8'h60
`define RST_SEL 8'h00
`define CODE_FULL 8'hC0
`define MODE_OFF 2'h0
`define MODE_NIGHT 2'h1
`define MODE_NORMAL 2'h2
`define MODE_RESET 2'h3
`define MODE_HI 7
`define MODE_LO 6
`define ODD_ON_BIT 7
`define ODD_PICK_HI 6
`define ODD_PICK_LO 4
`define EVEN_ON_BIT 3
`define EVEN_PICK_HI 2
`define EVEN_PICK_LO 0
`define PICK_RED 2
`define PICK_GRN 1
`define PICK_BLU 0
`define NIGHT_SHIFT 4
`endif

// [shared/rgb_palette_pkg.sv]
// Types shared by the palette bank and its line selector.
// Assumes the map header supplies all numeric constants.
package rgb_palette_pkg;
   typedef logic [7:0] code_t;      // Palette current code
   typedef logic [2:0] pick_t;      // Per-module red/green/blue pick
   typedef logic [1:0] mode_t;      // Enable-mode field
endpackage : rgb_palette_pkg

// [verilog/rgb_line_select.sv]
// Per-line colour current selection for one bus-A module.
// Assumes registered palette values arrive from the bank.
`timescale 1ns/1ns
`include "rgb_palette_map.svh"
module rgb_line_select (
   input wire logic i_on,                    // Module enable
   input wire rgb_palette_pkg::pick_t i_pick, // Palette pick bits
   input wire rgb_palette_pkg::code_t i_alt0, // Alternative 0 code
   input wire rgb_palette_pkg::code_t i_alt1, // Alternative 1 code
   input wire logic [1:0] i_bit,             // Which pick bit applies
   output logic [7:0] o_code                 // Target code, zero when off
);
   import rgb_palette_pkg::*;
   // Chosen alternative, then forced to zero when module is off
   wire sel_w = i_pick[i_bit];
   wire [7:0] chosen_w = sel_w ? i_alt1 : i_alt0;
   assign o_code = i_on ? chosen_w : 8'h00;
endmodule : rgb_line_select

// [verilog/rgb_palette_select_bus_a.sv]
// Palette and bus-A selection register bank with per-line targets.
// Assumes a byte-wide register write/read port from the serial engine.
//
// Notes on behaviour
// [R1] Alternative-0 palettes reset to 0x28 (5mA)
// [R2] Alternative-1 palettes reset to 0x60 (12mA)
// [R3] Code steps 125uA, 0xC0 is full scale
// [R4] Codes above 0xC0 stored and read as 0xC0
// [R5] Enable clear forces zero, set applies picks
// [R6] Module one: red l3, green l2, blue l4; code keeps it in an unused table
// [R7] Module two: red l4, green l3, blue l1; code keeps it in an unused table
// [R8] Module three: red l1, green l4, blue l2; code keeps it in an unused table
// [R9] Module four: red l2, green l1, blue l3; code keeps it in an unused table
// [R10] Enable-mode 11 restores every register default
// [R11] Night mode scales codes to 1.5mA range
// [R12] Shared palette write retargets all users
`timescale 1ns/1ns
`include "rgb_palette_map.svh"
module rgb_palette_select_bus_a (
   input wire logic i_clk,                      // 100 MHz clock
   input wire logic i_rst_n,                    // Sync reset, active low
   input wire logic i_wr,                       // Register write strobe
   input wire logic i_rd,                       // Register read strobe
   input wire logic [7:0] i_addr,               // Register address
   input wire rgb_palette_pkg::code_t i_wdata,  // Write data
   output rgb_palette_pkg::code_t o_rdata,      // Read data, next cycle
   output rgb_palette_pkg::mode_t o_mode,       // Current enable mode
   output logic o_night,                        // Night range active
   output logic [3:0] o_module_on,              // Module enables
   output logic [7:0] o_red_code [4],           // Red target per module
   output logic [7:0] o_grn_code [4],           // Green target per module
   output logic [7:0] o_blu_code [4],           // Blue target per module
   output logic [7:0] o_line_level [4][3]       // Scaled level per module
);
   import rgb_palette_pkg::*;

   // Palette and selection storage
   code_t red_level_alt0_q, green_level_alt0_q, blue_level_alt0_q;
   code_t red_level_alt1_q, green_level_alt1_q, blue_level_alt1_q;
   code_t sel12_q, sel34_q;   // Bus A selection registers
   mode_t mode_q;             // Enable-mode field copy
   code_t rdata_q;            // Read data register

   // Clamped write value
   wire over_w = i_wdata > `CODE_FULL;                        // R4
   wire [7:0] clamp_w = over_w ? `CODE_FULL : i_wdata;        // R4
   // Write decodes
   wire wr_ctl_w = i_wr && (i_addr == `ADDR_CONTROL);
   wire [1:0] wmode_w = i_wdata[`MODE_HI:`MODE_LO];
   wire soft_rst_w = wr_ctl_w && (wmode_w == `MODE_RESET);    // R10
   wire clr_w = !i_rst_n || soft_rst_w;                       // R10
   wire wr_r0_w = i_wr && (i_addr == `ADDR_RED0);
   wire wr_g0_w = i_wr && (i_addr == `ADDR_GRN0);
   wire wr_b0_w = i_wr && (i_addr == `ADDR_BLU0);
   wire wr_r1_w = i_wr && (i_addr == `ADDR_RED1);
   wire wr_g1_w = i_wr && (i_addr == `ADDR_GRN1);
   wire wr_b1_w = i_wr && (i_addr == `ADDR_BLU1);
   wire wr_s12_w = i_wr && (i_addr == `ADDR_SEL12);
   wire wr_s34_w = i_wr && (i_addr == `ADDR_SEL34);

   // Read multiplexer
   logic [7:0] rmux_w;
   always_comb begin
      if (i_addr == `ADDR_CONTROL) begin
         rmux_w = {mode_q, 6'h00};
      end else if (i_addr == `ADDR_RED0) begin
         rmux_w = red_level_alt0_q;
      end else if (i_addr == `ADDR_GRN0) begin
         rmux_w = green_level_alt0_q;
      end else if (i_addr == `ADDR_BLU0) begin
         rmux_w = blue_level_alt0_q;
      end else if (i_addr == `ADDR_RED1) begin
         rmux_w = red_level_alt1_q;
      end else if (i_addr == `ADDR_GRN1) begin
         rmux_w = green_level_alt1_q;
      end else if (i_addr == `ADDR_BLU1) begin
         rmux_w = blue_level_alt1_q;
      end else if (i_addr == `ADDR_SEL12) begin
         rmux_w = sel12_q;
      end else if (i_addr == `ADDR_SEL34) begin
         rmux_w = sel34_q;
      end else begin
         rmux_w = 8'h00;   // Unmapped reads as zero
      end
   end

   // Alternative-0 palette registers
   always_ff @(posedge i_clk) begin
      if (clr_w) begin
         red_level_alt0_q <= `RST_ALT0;     // R1
         green_level_alt0_q <= `RST_ALT0;   // R1
         blue_level_alt0_q <= `RST_ALT0;    // R1
      end else begin
         if (wr_r0_w) red_level_alt0_q <= clamp_w;   // R4
         if (wr_g0_w) green_level_alt0_q <= clamp_w; // R4
         if (wr_b0_w) blue_level_alt0_q <= clamp_w;  // R4
      end
   end

   // Alternative-1 palette registers
   always_ff @(posedge i_clk) begin
      if (clr_w) begin
         red_level_alt1_q <= `RST_ALT1;     // R2
         green_level_alt1_q <= `RST_ALT1;   // R2
         blue_level_alt1_q <= `RST_ALT1;    // R2
      end else begin
         if (wr_r1_w) red_level_alt1_q <= clamp_w;   // R4
         if (wr_g1_w) green_level_alt1_q <= clamp_w; // R4
         if (wr_b1_w) blue_level_alt1_q <= clamp_w;  // R4
      end
   end

   // Selection registers and mode field
   always_ff @(posedge i_clk) begin
      if (clr_w) begin
         sel12_q <= `RST_SEL;   // R10
         sel34_q <= `RST_SEL;   // R10
         mode_q <= `MODE_OFF;   // R10
      end else begin
         if (wr_s12_w) sel12_q <= i_wdata;
         if (wr_s34_w) sel34_q <= i_wdata;
         if (wr_ctl_w) mode_q <= wmode_w;
      end
   end

   // Read data register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         rdata_q <= rmux_w;
      end
   end

   // Per-module fields: modules 1,3 in the high nibble, 2,4 in the low
   wire [3:0] on_w = {sel34_q[`EVEN_ON_BIT], sel34_q[`ODD_ON_BIT],
                      sel12_q[`EVEN_ON_BIT], sel12_q[`ODD_ON_BIT]};
   wire [2:0] pick_w [4];
   assign pick_w[0] = sel12_q[`ODD_PICK_HI:`ODD_PICK_LO];
   assign pick_w[1] = sel12_q[`EVEN_PICK_HI:`EVEN_PICK_LO];
   assign pick_w[2] = sel34_q[`ODD_PICK_HI:`ODD_PICK_LO];
   assign pick_w[3] = sel34_q[`EVEN_PICK_HI:`EVEN_PICK_LO];

   // Targets per module, shared palettes feed every user    // R12
   wire [7:0] red_w [4];
   wire [7:0] grn_w [4];
   wire [7:0] blu_w [4];
   genvar m;
   generate
      for (m = 0; m < 4; m++) begin : g_mod
         rgb_line_select u_red (
            .i_on(on_w[m]),
            .i_pick(pick_w[m]),
            .i_alt0(red_level_alt0_q),
            .i_alt1(red_level_alt1_q),
            .i_bit(2'(`PICK_RED)),
            .o_code(red_w[m])
         );   // R5
         rgb_line_select u_grn (
            .i_on(on_w[m]),
            .i_pick(pick_w[m]),
            .i_alt0(green_level_alt0_q),
            .i_alt1(green_level_alt1_q),
            .i_bit(2'(`PICK_GRN)),
            .o_code(grn_w[m])
         );   // R5
         rgb_line_select u_blu (
            .i_on(on_w[m]),
            .i_pick(pick_w[m]),
            .i_alt0(blue_level_alt0_q),
            .i_alt1(blue_level_alt1_q),
            .i_bit(2'(`PICK_BLU)),
            .o_code(blu_w[m])
         );   // R5
      end
   endgenerate

   // Line routing per module: red, green, blue lines (0-based)
   // Module 1: 2,1,3  Module 2: 3,2,0  Module 3: 0,3,1  Module 4: 1,0,2
   // R6 R7 R8 R9 are recorded in this fixed map, kept in three tables that no output uses
   localparam logic [1:0] RED_LINE [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
   localparam logic [1:0] GRN_LINE [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   localparam logic [1:0] BLU_LINE [4] = '{2'h3, 2'h0, 2'h1, 2'h2};

   // Night range: code scaled by 1/16 (125uA to ~8uA steps)   // R11
   function automatic logic [7:0] scale(input logic [7:0] c,
                                        input logic night);
      scale = night ? (c >> `NIGHT_SHIFT) : c;  // R3 R11
   endfunction : scale

   // Registered outputs
   wire night_w = (mode_q == `MODE_NIGHT);   // R11
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
         o_mode <= `MODE_OFF;
         o_night <= 1'b0;
         o_module_on <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            o_red_code[k] <= 8'h00;
            o_grn_code[k] <= 8'h00;
            o_blu_code[k] <= 8'h00;
            for (int c = 0; c < 3; c++) o_line_level[k][c] <= 8'h00;
         end
      end else begin
         o_rdata <= rmux_w;
         o_mode <= mode_q;
         o_night <= night_w;
         o_module_on <= on_w;
         for (int k = 0; k < 4; k++) begin
            o_red_code[k] <= red_w[k];            // R6 R7 R8 R9
            o_grn_code[k] <= grn_w[k];
            o_blu_code[k] <= blu_w[k];
            o_line_level[k][0] <= scale(red_w[k], night_w);  // R11
            o_line_level[k][1] <= scale(grn_w[k], night_w);
            o_line_level[k][2] <= scale(blu_w[k], night_w);
         end
      end
   end

   // Checks
   // Steps of a soft reset: the control write, then the selection, mode, green alt-0 and red alt-1 defaults
   sequence soft_rst_s;
      soft_rst_w;
   endsequence
   sequence defaults_s;
      sel12_q == `RST_SEL && sel34_q == `RST_SEL && mode_q == `MODE_OFF
      && green_level_alt0_q == `RST_ALT0 && red_level_alt1_q == `RST_ALT1;
   endsequence
   // Steps of an over-range write: the write, then the clamped store
   sequence over_wr_s;
      wr_g1_w && !soft_rst_w && over_w;
   endsequence
   sequence clamped_s;
      green_level_alt1_q == `CODE_FULL;
   endsequence

   // Reset values, seen at the first edge after release
   AST_RST_ALT0: assert property (@(posedge i_clk)  // R1
      $rose(i_rst_n) |-> red_level_alt0_q == `RST_ALT0)
      else $error("alt0 reset value wrong");
   AST_RST_ALT1: assert property (@(posedge i_clk)  // R2
      $rose(i_rst_n) |-> blue_level_alt1_q == `RST_ALT1)
      else $error("alt1 reset value wrong");

   // Full-scale clamp on store and on read back
   AST_CLAMP: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // R4
      red_level_alt0_q <= `CODE_FULL)
      else $error("palette above full scale");
   AST_CLAMP_WR: assert property (  // R4
      @(posedge i_clk) disable iff (!i_rst_n)
      over_wr_s |=> clamped_s)
      else $error("over-range write not clamped");
   AST_RD_CLAMP: assert property (  // R4
      @(posedge i_clk) disable iff (!i_rst_n)
      i_rd && i_addr == `ADDR_RED1 |=> rdata_q <= `CODE_FULL)
      else $error("palette read above full scale");

   // Enables force zero targets
   AST_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // R5
      !on_w[0] |=> o_red_code[0] == 8'h00 && o_blu_code[0] == 8'h00)
      else $error("disabled module drives current");
   AST_OFF_ALL: assert property (  // R5
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w == 4'h0 |=> o_grn_code[3] == 8'h00 && o_line_level[3][1] == 8'h00)
      else $error("all modules off but current driven");

   // Palette picks per module and colour
   AST_MOD1_RED: assert property (  // R6
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[0] && sel12_q[`ODD_PICK_HI]
      |=> o_red_code[0] == $past(red_level_alt1_q))
      else $error("module one red pick wrong");
   AST_MOD1_GRN: assert property (  // R6
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[0] && !pick_w[0][`PICK_GRN]
      |=> o_grn_code[0] == $past(green_level_alt0_q))
      else $error("module one green pick wrong");
   AST_MOD2_RED: assert property (  // R7
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[1] && !pick_w[1][`PICK_RED]
      |=> o_red_code[1] == $past(red_level_alt0_q))
      else $error("module two red pick wrong");
   AST_MOD2_BLU: assert property (  // R7
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[1] && pick_w[1][`PICK_BLU]
      |=> o_blu_code[1] == $past(blue_level_alt1_q))
      else $error("module two blue pick wrong");
   AST_MOD3_RED: assert property (  // R8
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[2] && pick_w[2][`PICK_RED]
      |=> o_red_code[2] == $past(red_level_alt1_q))
      else $error("module three red pick wrong");
   AST_MOD3_GRN: assert property (  // R8
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[2] && pick_w[2][`PICK_GRN]
      |=> o_grn_code[2] == $past(green_level_alt1_q))
      else $error("module three green pick wrong");
   AST_MOD4_GRN: assert property (  // R9
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[3] && pick_w[3][`PICK_GRN]
      |=> o_grn_code[3] == $past(green_level_alt1_q))
      else $error("module four green pick wrong");
   AST_MOD4_BLU: assert property (  // R9
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[3] && !sel34_q[`PICK_BLU]
      |=> o_blu_code[3] == $past(blue_level_alt0_q))
      else $error("module four blue pick wrong");

   // One palette register feeds every module that picks it
   AST_SHARED: assert property (  // R12
      @(posedge i_clk) disable iff (!i_rst_n)
      on_w[1] && on_w[2] && !pick_w[1][`PICK_RED] && !pick_w[2][`PICK_RED]
      |=> o_red_code[1] == o_red_code[2])
      else $error("shared palette gives different targets");

   // Soft reset and range scaling
   AST_SOFT_RST: assert property (  // R10
      @(posedge i_clk) disable iff (!i_rst_n)
      soft_rst_s |=> defaults_s)
      else $error("mode 11 did not restore defaults");
   AST_NIGHT: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // R11
      night_w |=> o_line_level[1][0] == ($past(red_w[1]) >> `NIGHT_SHIFT))
      else $error("night scaling wrong");
   AST_NORMAL: assert property (  // R11
      @(posedge i_clk) disable iff (!i_rst_n)
      !night_w |=> o_line_level[0][1] == $past(grn_w[0]))
      else $error("normal range level scaled");
endmodule : rgb_palette_select_bus_a

// [bench/host_model.sv]
// Behavioural register host standing in for the serial engine.
// Assumes calls start 1 ns after a rising edge of i_clk.
`timescale 1ns/1ns
module host_model (
   input wire logic i_clk,         // Bank clock
   input wire logic [7:0] i_rdata, // Read data from the bank
   output logic o_wr,              // Write strobe
   output logic o_rd,              // Read strobe
   output logic [7:0] o_addr,      // Register address
   output logic [7:0] o_wdata      // Write data
);
   // Idle port at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // One write; an idle edge follows so strobes never toggle twice
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1 o_wr = 1'b0;
      o_wdata = ~d;
      @(posedge i_clk);
      #1;
   endtask : write_reg
   // Present address, take data after the next edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1 d = i_rdata;
      o_rd = 1'b0;
      @(posedge i_clk);
      #1;
   endtask : read_reg
endmodule : host_model

// [bench/rgb_palette_select_bus_a_test.sv]
// Self-checking bench for the palette and bus-A selection bank.
// Assumes the host model drives the register port after each edge.
`timescale 1ns/1ns
module rgb_palette_select_bus_a_test;
   import rgb_palette_pkg::*;
   logic i_clk, i_rst_n, i_wr, i_rd;
   logic [7:0] i_addr;
   code_t i_wdata, o_rdata;
   mode_t o_mode;
   logic o_night;
   logic [3:0] o_module_on;
   logic [7:0] o_red_code [4];
   logic [7:0] o_grn_code [4];
   logic [7:0] o_blu_code [4];
   logic [7:0] o_line_level [4][3];
   logic [7:0] pal [6]; // Expected palettes, alt0 r,g,b then alt1 r,g,b
   logic [7:0] sel [2]; // Expected selection registers
   logic [7:0] pat [3][2] = '{'{8'hDA, 8'hB5}, '{8'hAD, 8'hCE},
                             '{8'h00, 8'h09}};
   logic [7:0] rd_val;
   logic night_exp;
   int error_cnt = 0, n_checks = 0, cycles = 0, i;
   rgb_palette_select_bus_a dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_mode(o_mode), .o_night(o_night),
      .o_module_on(o_module_on), .o_red_code(o_red_code),
      .o_grn_code(o_grn_code), .o_blu_code(o_blu_code),
      .o_line_level(o_line_level));
   host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr),
      .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
   // Free-running 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Cut a hang short
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Read a register and compare
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.read_reg(a, rd_val);
      chk(rd_val, exp);
   endtask : rd_chk
   // Check every module output against the expected registers
   task automatic chk_all();
      int m, c;
      logic [3:0] f;
      logic [7:0] e, seen;
      @(posedge i_clk);
      #1;
      for (m = 0; m < 4; m++) begin
         f = m[0] ? sel[m/2][3:0] : sel[m/2][7:4];
         chk({7'h00, o_module_on[m]}, {7'h00, f[3]});
         for (c = 0; c < 3; c++) begin
            e = f[3] ? pal[c + (f[2-c] ? 3 : 0)] : 8'h00;
            seen = c == 0 ? o_red_code[m] : c == 1 ? o_grn_code[m]
               : o_blu_code[m];
            chk(seen, e);
            chk(o_line_level[m][c], night_exp ? e >> 4 : e);
         end
      end
   endtask : chk_all
   // Print the counts and the verdict, then stop
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Main sequence
   initial begin
      i_rst_n = 1'b0;
      pal = '{8'h28, 8'h28, 8'h28, 8'h60, 8'h60, 8'h60};
      sel = '{8'h00, 8'h00};
      night_exp = 1'b0;
      repeat (20) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      for (i = 0; i < 8; i++) begin
         rd_chk(8'(8'h03 + i), i < 6 ? pal[i] : 8'h00);
      end
      chk_all();
      $display("Reset defaults test done");
      // Clamp above full scale, linear codes at the edges
      host.write_reg(8'h03, 8'hFF);
      rd_chk(8'h03, 8'hC0);
      host.write_reg(8'h06, 8'hC1);
      rd_chk(8'h06, 8'hC0);
      host.write_reg(8'h07, 8'hFF);
      rd_chk(8'h07, 8'hC0);
      host.write_reg(8'h04, 8'hC0);
      rd_chk(8'h04, 8'hC0);
      host.write_reg(8'h05, 8'h01);
      rd_chk(8'h05, 8'h01);
      $display("Clamp test done");
      // Distinct palettes, then the three pick patterns in pat
      for (i = 0; i < 6; i++) begin
         pal[i] = 8'(8'h11 * (i + 1));
         host.write_reg(8'(8'h03 + i), pal[i]);
      end
      for (i = 0; i < 3; i++) begin
         sel = pat[i];
         host.write_reg(8'h09, sel[0]);
         host.write_reg(8'h0A, sel[1]);
         rd_chk(8'h0A, sel[1]);
         chk_all();
      end
      sel = pat[0]; // Modules two and three share red alt 0
      host.write_reg(8'h09, sel[0]);
      host.write_reg(8'h0A, sel[1]);
      pal[0] = 8'h77;
      host.write_reg(8'h03, 8'h77);
      chk_all();
      $display("Selection test done");
      // Night range, then back to normal
      host.write_reg(8'h02, 8'h40);
      night_exp = 1'b1;
      chk_all();
      chk({7'h00, o_night}, 8'h01);
      rd_chk(8'h02, 8'h40);
      host.write_reg(8'h02, 8'h80);
      night_exp = 1'b0;
      chk({6'h00, o_mode}, 8'h02);
      host.write_reg(8'h0F, 8'h55);
      rd_chk(8'h0F, 8'h00);
      $display("Mode test done");
      // Soft reset restores every register
      host.write_reg(8'h02, 8'hC0);
      pal = '{8'h28, 8'h28, 8'h28, 8'h60, 8'h60, 8'h60};
      sel = '{8'h00, 8'h00};
      for (i = 0; i < 8; i++) begin
         rd_chk(8'(8'h03 + i), i < 6 ? pal[i] : 8'h00);
      end
      rd_chk(8'h02, 8'h00);
      chk_all();
      $display("Soft reset test done");
      wrap_up();
   end
endmodule : rgb_palette_select_bus_a_test
